/* File: logic/pnp_pkg.sv */
// Constants, types and lookup functions of the ISA plug and play block.
`default_nettype none
package pnp_pkg;
  // ISA port addresses.
  localparam logic [11:0] ADDR_PORT  = 12'h279;
  localparam logic [11:0] WDATA_PORT = 12'ha79;
  // Register indexes.
  localparam logic [7:0] IDX_SET_RD   = 8'h00;
  localparam logic [7:0] IDX_ISO      = 8'h01;
  localparam logic [7:0] IDX_CFG_CTL  = 8'h02;
  localparam logic [7:0] IDX_WAKE     = 8'h03;
  localparam logic [7:0] IDX_CSN      = 8'h06;
  localparam logic [7:0] IDX_LDN      = 8'h07;
  localparam logic [7:0] IDX_IO_HI    = 8'h60;
  localparam logic [7:0] IDX_IO_LO    = 8'h61;
  localparam logic [7:0] IDX_IRQ_LVL  = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
  localparam logic [7:0] IDX_AUTO     = 8'hf0;
  localparam logic [7:0] IDX_SENSE_EN = 8'hf1;
  localparam logic [7:0] IDX_SENSE    = 8'hf2;
  localparam logic [7:0] IDX_MCU_WAKE = 8'hf3;
  // Fixed values, reset values and field positions.
  localparam logic [7:0]  IRQ_TYPE_VAL = 8'h02;
  localparam logic [7:0]  AUTO_CFG_RST = 8'h04;
  localparam logic [15:0] IO_BASE_RST  = 16'h03f8;
  localparam logic [3:0]  IRQ_RST      = 4'h4;
  localparam logic [7:0]  RD_PORT_RST  = 8'h00;
  localparam int SEN_LATCH_BIT = 0;
  localparam int SEN_PULL_BIT  = 1;
  localparam int MCU_WAKE_BIT  = 0;
  localparam int CTL_RESET_BIT = 0;
  localparam int CTL_WKEY_BIT  = 1;
  localparam int CTL_RCSN_BIT  = 2;
  // Isolation protocol.
  localparam logic [7:0] ISO_FIRST  = 8'h55;
  localparam logic [7:0] ISO_SECOND = 8'haa;
  localparam logic [1:0] SENSE_ONE  = 2'b01;
  localparam logic [1:0] SENSE_TWO  = 2'b10;
  localparam logic [6:0] ID_BITS    = 7'd72;
  localparam logic [4:0] KEY_LAST   = 5'd31;
  // I/O bases chosen by auto configuration bits 5:4, entry 0 lowest.
  localparam logic [63:0] AUTO_BASES = 64'h02e8_03e8_02f8_03f8;
  // Initiation keys, first byte in bits 7:0.
  localparam logic [255:0] KEY_PNP = {
    64'h3973e7ce_9d3a74e8, 64'hd1a2458b_162c58b0,
    64'h61c3860d_1b376fdf, 64'hbe7dfbf6_eddab56a};
  localparam logic [255:0] KEY_VEND = {
    64'h5dbb76ec_d9b265cb, 64'h962d5bb7_6edcb972,
    64'he4c99225_4b972e5c, 64'hb871e3cb_8d1a3468};

  typedef enum logic [1:0] {
    ST_WAIT_KEY, ST_SLEEP, ST_ISOLATE, ST_CONFIG
  } pnp_state_t;

  function automatic logic [7:0] key_byte(input logic       vend,
                                          input logic [4:0] pos);
    key_byte = vend ? KEY_VEND[pos*8 +: 8] : KEY_PNP[pos*8 +: 8];
  endfunction

  function automatic logic [15:0] auto_base(input logic [1:0] sel);
    auto_base = AUTO_BASES[sel*16 +: 16];
  endfunction
endpackage
`default_nettype wire

/* File: logic/pnp_key_detect.sv */
// Detector for the two 32-write initiation keys.
`timescale 1ns/10ps
`default_nettype none
module pnp_key_detect
  import pnp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr,
  input  wire logic [7:0] data,
  output logic            pnp_hit,
  output logic            vend_hit
);
  logic [4:0] pos_ff [2];
  logic [1:0] hit_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos_ff[0] <= '0;
      pos_ff[1] <= '0;
      hit_ff    <= '0;
    end else begin
      hit_ff <= '0;
      if (wr) begin
        for (int i = 0; i < 2; i++) begin
          if (data == key_byte(i[0], pos_ff[i])) begin
            pos_ff[i] <= pos_ff[i] + 5'd1;
            hit_ff[i] <= (pos_ff[i] == KEY_LAST);
          end else begin
            pos_ff[i] <= '0;
          end
        end
      end
    end
  end

  assign pnp_hit  = hit_ff[0];
  assign vend_hit = hit_ff[1];

  chk_key_restart: assert property (@(posedge clk) disable iff (!rst_n)
    wr && data != key_byte(1'b0, pos_ff[0]) |=> pos_ff[0] == 5'd0)
    else $error("Key position did not restart on a mismatch.");
endmodule // pnp_key_detect
`default_nettype wire

/* File: logic/pnp_isolate.sv */
// Serial identifier walker and sensing for the isolation protocol.
`timescale 1ns/10ps
`default_nettype none
module pnp_isolate
  import pnp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        restart,
  input  wire logic        sense,
  input  wire logic [1:0]  sd_low,
  input  wire logic [71:0] id,
  output logic             bit_one,
  output logic             second,
  output logic             lost,
  output logic             done
);
  logic [6:0] idx_ff;
  logic       phase_ff;
  logic       saw_ff;
  logic       lost_ff;

  // Only the low two data bits are compared.
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      idx_ff   <= '0;
      phase_ff <= 1'b0;
      saw_ff   <= 1'b0;
      lost_ff  <= 1'b0;
    end else begin
      lost_ff <= 1'b0;
      if (sense && !done) begin
        phase_ff <= !phase_ff;
        if (!phase_ff) begin
          saw_ff <= !bit_one && sd_low == SENSE_ONE;
        end else if (!bit_one && saw_ff && sd_low == SENSE_TWO) begin
          lost_ff <= 1'b1;
        end else begin
          idx_ff <= idx_ff + 7'd1;
        end
      end
    end
  end

  assign done    = idx_ff == ID_BITS;
  assign bit_one = !done && id[idx_ff];
  assign second  = phase_ff;
  assign lost    = lost_ff;

  chk_id_advance: assert property (@(posedge clk) disable iff (!rst_n)
    sense && phase_ff && !done && !restart && bit_one
    |=> idx_ff == $past(idx_ff) + 7'd1)
    else $error("Identifier did not advance after a won pair.");
endmodule // pnp_isolate
`default_nettype wire

/* File: logic/pnp_cfg_top.sv */
// ISA plug and play configuration, key detection and isolation logic.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - I/O base held in readable, writable high and low registers.
// - Interrupt level bits 3:0 pick IRQn; zero selects no line.
// - Interrupt type register is read only and reads 0x02.
// - Auto configuration register written by host or microcontroller.
// - Sense enable bit 0 latches IRQ lines, bit 1 enables pull-lows.
// - Sense register bits 0 to 7 show IRQ 3,4,5,7,10,11,12,15.
// - Wake bit 0 pulses controller wake and clears itself.
// - Power on in vendor jumperless mode, defaults loaded from EEPROM.
// - Host I/O base, IRQ level and CSN writes are lost at the next host reset.
// - Data ports open only after a full key; mismatch restarts.
// - Standard key starts 6A B5 DA and ends 73 39.
// - Vendor key starts 68 34 1A and ends BB 5D.
// - A non-zero 72-bit identifier: vendor, serial, checksum.
// - Identifier bits go out least significant bit first.
// - A one bit answers 0x55 then 0xAA; a zero leaves bus floating.
// - Floating card seeing 01 then 10 drops out of the iteration.
// - All eight bits driven, only the low two compared.
// - After each pair not lost, advance one identifier bit.
// - Cards with a CSN skip isolation; without one ignore commands.
// - Read port address bits 9:2 from set-port, bits 1:0 ones.
// - Wake with data zero enters isolation and rewinds the pointer.
module pnp_cfg_top
  import pnp_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        RSTDRV,
  input  wire logic [11:0] SA,
  input  wire logic        IOW,
  input  wire logic        IOR,
  input  wire logic [7:0]  SD_IN,
  output logic      [7:0]  SD_OUT,
  output logic             SD_OE_N,
  input  wire logic [7:0]  IRQ_LINES,
  input  wire logic [71:0] SERIAL_ID,
  input  wire logic        EE_CFG_VALID,
  input  wire logic [7:0]  EE_CFG_DATA,
  input  wire logic        MCU_CFG_WE,
  input  wire logic [7:0]  MCU_CFG_DATA,
  output logic      [7:0]  AUTO_CFG,
  output logic             AUTO_CFG_WR,
  output logic      [15:0] IO_BASE,
  output logic      [3:0]  IRQ_SEL,
  output logic             IRQ_PULL_LOW,
  output logic             MCU_WAKE,
  output logic             VENDOR_JUMPERLESS_MODE
);
  import pnp_pkg::*;

  pnp_state_t  state_ff;
  logic [7:0]  index_ff;
  logic [7:0]  rd_port_ff;
  logic [7:0]  csn_ff;
  logic [7:0]  io_hi_ff;
  logic [4:0]  io_lo_ff;
  logic [3:0]  irq_ff;
  logic [7:0]  auto_ff;
  logic [7:0]  sense_ff;
  logic        pull_ff;
  logic        mcu_wake_ff;
  logic        auto_wr_ff;
  logic        apply_ff;
  logic        jl_mode_ff;
  logic [7:0]  dout_ff;
  logic        drive_ff;
  logic        iso_sense_ff;
  logic [7:0]  rd_mux;
  logic [15:0] auto_io;
  logic        unlocked;
  logic        cfg_ok;
  logic        addr_wr;
  logic        data_wr;
  logic        data_rd;
  logic        iso_rd;
  logic        cfg_wr;
  logic        wake_wr;
  logic        ctl_wr;
  logic        wake_iso;
  logic        key_pnp;
  logic        key_vend;
  logic        iso_bit;
  logic        iso_second;
  logic        iso_lost;
  logic        iso_done;

  ////////////////////////////////////////////////////////////////////////////
  // Port decode.

  assign unlocked = state_ff != ST_WAIT_KEY;
  assign cfg_ok   = state_ff == ST_CONFIG;
  assign addr_wr  = IOW && SA == ADDR_PORT;
  assign data_wr  = IOW && SA == WDATA_PORT && unlocked;
  assign data_rd  = IOR && SA == {2'b00, rd_port_ff, 2'b11} && unlocked;
  assign iso_rd   = data_rd && state_ff == ST_ISOLATE && index_ff == IDX_ISO;
  assign cfg_wr   = data_wr && cfg_ok;
  assign wake_wr  = data_wr && index_ff == IDX_WAKE;
  assign ctl_wr   = data_wr && index_ff == IDX_CFG_CTL;
  // A card that already owns a CSN never rejoins isolation.
  assign wake_iso = wake_wr && SD_IN == 8'h00 && csn_ff == 8'h00;
  assign auto_io  = auto_base(auto_ff[5:4]);

  pnp_key_detect u_key (
    .clk      (CLK),
    .rst_n    (RST_N),
    .wr       (addr_wr),
    .data     (SD_IN),
    .pnp_hit  (key_pnp),
    .vend_hit (key_vend)
  );

  pnp_isolate u_iso (
    .clk     (CLK),
    .rst_n   (RST_N),
    .restart (wake_iso),
    .sense   (iso_sense_ff),
    .sd_low  (SD_IN[1:0]),
    .id      (SERIAL_ID),
    .bit_one (iso_bit),
    .second  (iso_second),
    .lost    (iso_lost),
    .done    (iso_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Card state and card control.

  always_ff @(posedge CLK) begin
    if (!RST_N || RSTDRV) begin
      state_ff <= ST_WAIT_KEY;
    end else if (ctl_wr && SD_IN[CTL_WKEY_BIT]) begin
      state_ff <= ST_WAIT_KEY;
    end else begin
      case (state_ff)
        ST_WAIT_KEY: begin
          if (key_pnp || key_vend) state_ff <= ST_SLEEP;
        end
        ST_SLEEP: begin
          if (wake_iso) state_ff <= ST_ISOLATE;
          else if (wake_wr && SD_IN == csn_ff) state_ff <= ST_CONFIG;
        end
        ST_ISOLATE: begin
          if (iso_lost) state_ff <= ST_SLEEP;
          else if (data_wr && index_ff == IDX_CSN && iso_done) begin
            state_ff <= ST_CONFIG;
          end else if (wake_wr && !wake_iso) state_ff <= ST_SLEEP;
        end
        ST_CONFIG: begin
          if (wake_iso) state_ff <= ST_ISOLATE;
          else if (wake_wr && SD_IN != csn_ff) state_ff <= ST_SLEEP;
        end
        default: state_ff <= ST_WAIT_KEY;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N || RSTDRV) begin
      csn_ff <= 8'h00;
    end else if (ctl_wr && SD_IN[CTL_RCSN_BIT]) begin
      csn_ff <= 8'h00;
    end else if (data_wr && index_ff == IDX_CSN && (cfg_ok || iso_done)) begin
      csn_ff <= SD_IN;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      index_ff   <= 8'h00;
      rd_port_ff <= RD_PORT_RST;
    end else begin
      if (addr_wr && unlocked) index_ff <= SD_IN;
      if (data_wr && index_ff == IDX_SET_RD && state_ff == ST_ISOLATE) begin
        rd_port_ff <= SD_IN;
      end
    end
  end

  // A vendor key after power-on keeps the card jumperless.
  always_ff @(posedge CLK) begin
    if (!RST_N) jl_mode_ff <= 1'b1;
    else if (key_vend) jl_mode_ff <= 1'b1;
    else if (key_pnp) jl_mode_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auto configuration and logical device configuration.

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      auto_ff    <= AUTO_CFG_RST;
      auto_wr_ff <= 1'b0;
    end else begin
      auto_wr_ff <= cfg_wr && index_ff == IDX_AUTO && !EE_CFG_VALID
        && !MCU_CFG_WE;
      if (EE_CFG_VALID) auto_ff <= EE_CFG_DATA;
      else if (MCU_CFG_WE) auto_ff <= MCU_CFG_DATA;
      else if (cfg_wr && index_ff == IDX_AUTO) auto_ff <= SD_IN;
    end
  end

  // Applying one cycle late lets every source of the auto value share one
  // path; host edits stay until a host reset, a new auto value or the control reset bit reloads them.
  always_ff @(posedge CLK) begin
    if (!RST_N) apply_ff <= 1'b0;
    else apply_ff <= RSTDRV || EE_CFG_VALID || MCU_CFG_WE
      || (cfg_wr && index_ff == IDX_AUTO)
      || (ctl_wr && SD_IN[CTL_RESET_BIT]);
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      io_hi_ff <= IO_BASE_RST[15:8];
      io_lo_ff <= IO_BASE_RST[7:3];
      irq_ff   <= IRQ_RST;
    end else if (apply_ff) begin
      io_hi_ff <= auto_io[15:8];
      io_lo_ff <= auto_io[7:3];
      irq_ff   <= auto_ff[3:0];
    end else if (cfg_wr) begin
      if (index_ff == IDX_IO_HI) io_hi_ff <= SD_IN;
      if (index_ff == IDX_IO_LO) io_lo_ff <= SD_IN[7:3];
      if (index_ff == IDX_IRQ_LVL) irq_ff <= SD_IN[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vendor registers: IRQ line sensing and controller wake.

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sense_ff    <= 8'h00;
      pull_ff     <= 1'b0;
      mcu_wake_ff <= 1'b0;
    end else begin
      mcu_wake_ff <= cfg_wr && index_ff == IDX_MCU_WAKE
        && SD_IN[MCU_WAKE_BIT];
      if (cfg_wr && index_ff == IDX_SENSE_EN) begin
        pull_ff <= SD_IN[SEN_PULL_BIT];
        if (SD_IN[SEN_LATCH_BIT]) sense_ff <= IRQ_LINES;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data.

  always_comb begin
    case (index_ff)
      IDX_CSN:      rd_mux = csn_ff;
      IDX_IO_HI:    rd_mux = io_hi_ff;
      IDX_IO_LO:    rd_mux = {io_lo_ff, 3'b000};
      IDX_IRQ_LVL:  rd_mux = {4'h0, irq_ff};
      IDX_IRQ_TYPE: rd_mux = IRQ_TYPE_VAL;
      IDX_AUTO:     rd_mux = auto_ff;
      IDX_SENSE:    rd_mux = sense_ff;
      default:      rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dout_ff      <= 8'h00;
      drive_ff     <= 1'b0;
      iso_sense_ff <= 1'b0;
    end else begin
      iso_sense_ff <= iso_rd;
      drive_ff     <= 1'b0;
      if (iso_rd) begin
        drive_ff <= iso_bit;
        dout_ff  <= iso_second ? ISO_SECOND : ISO_FIRST;
      end else if (data_rd && cfg_ok) begin
        drive_ff <= 1'b1;
        dout_ff  <= rd_mux;
      end
    end
  end

  assign SD_OUT                 = dout_ff;
  assign SD_OE_N                = !drive_ff;
  assign AUTO_CFG               = auto_ff;
  assign AUTO_CFG_WR            = auto_wr_ff;
  assign IO_BASE                = {io_hi_ff, io_lo_ff, 3'b000};
  assign IRQ_SEL                = irq_ff;
  assign IRQ_PULL_LOW           = pull_ff;
  assign MCU_WAKE               = mcu_wake_ff;
  assign VENDOR_JUMPERLESS_MODE = jl_mode_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  chk_key_unlock: assert property ($rose(unlocked) |->
    $past(key_pnp) || $past(key_vend))
    else $error("Data ports opened without an initiation key.");
  chk_read_port: assert property (IOR && SA[1:0] != 2'b11 |=> SD_OE_N)
    else $error("Card answered on a port without low bits set.");
  chk_iso_first: assert property (iso_rd && iso_bit && !iso_second
    |=> !SD_OE_N && SD_OUT == 8'h55)
    else $error("First isolation read did not return 0x55.");
  chk_iso_second: assert property (iso_rd && iso_bit && iso_second
    |=> !SD_OE_N && SD_OUT == 8'haa)
    else $error("Second isolation read did not return 0xAA.");
  chk_iso_float: assert property (iso_rd && !iso_bit |=> SD_OE_N)
    else $error("Card drove the bus for a zero bit.");
  chk_drop_out: assert property (iso_lost && !RSTDRV |=>
    state_ff == ST_SLEEP || state_ff == ST_WAIT_KEY)
    else $error("Losing card did not leave isolation.");
  chk_irq_type: assert property (data_rd && cfg_ok
    && index_ff == IDX_IRQ_TYPE |=> SD_OUT == 8'h02)
    else $error("Interrupt type did not read 0x02.");
  chk_sense_latch: assert property (cfg_wr && index_ff == IDX_SENSE_EN
    && SD_IN[0] |=> sense_ff == $past(IRQ_LINES))
    else $error("IRQ lines were not latched.");
  chk_mcu_wake: assert property (cfg_wr && index_ff == IDX_MCU_WAKE
    && SD_IN[0] |=> MCU_WAKE)
    else $error("Controller wake was not raised.");
  chk_csn_skip: assert property (wake_wr && csn_ff != 8'h00
    |=> state_ff != ST_ISOLATE)
    else $error("Card with a CSN entered isolation.");
  chk_temp_cfg: assert property (RSTDRV ##1 !(EE_CFG_VALID || MCU_CFG_WE)
    |=> IO_BASE == auto_base(auto_ff[5:4]))
    else $error("Host reset did not restore the default I/O base.");

  cov_key_pnp:  cover property (key_pnp);
  cov_iso_lost: cover property (iso_lost);
  cov_config:   cover property (iso_done && state_ff == ST_CONFIG);
  cov_wake:     cover property (MCU_WAKE);
endmodule // pnp_cfg_top
`default_nettype wire

/* File: sim/pnp_host.sv */
// ISA host model: I/O cycles, key writes and a rival card on the data bus.
`timescale 1ns/10ps
`default_nettype none
module pnp_host
  import pnp_pkg::*;
(
  input  wire logic       clk,
  output logic [11:0]     sa,
  output logic            iow,
  output logic            ior,
  output logic [7:0]      sd_in,
  input  wire logic [7:0] sd_out,
  input  wire logic       sd_oe_n
);
  logic [7:0]  host_val = 8'h00;
  logic        host_en  = 1'b0;
  logic [7:0]  other_val = 8'h00;
  logic        other_en = 1'b0;
  logic [7:0]  last_val = 8'h00;
  logic [11:0] rd_port  = 12'h003;
  initial begin
    sa = 12'h000;
    iow = 1'b0;
    ior = 1'b0;
  end
  // A floating bus shows the inverse of its last value, so a stale copy
  // can never pass for a real answer.
  always_comb begin
    if (!sd_oe_n) sd_in = sd_out;
    else if (host_en) sd_in = host_val;
    else if (other_en) sd_in = other_val;
    else sd_in = ~last_val;
  end
  always @(posedge clk) last_val <= sd_in;
  // Strobes start two cycles apart so the card has its sensing cycle.
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    sa = a;
    host_val = v;
    host_en = 1'b1;
    iow = 1'b1;
    @(posedge clk); #2;
    iow = 1'b0;
    host_en = 1'b0;
    @(posedge clk); #2;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] v,
                    output logic oe);
    sa = a;
    ior = 1'b1;
    @(posedge clk); #2;
    ior = 1'b0;
    v = sd_out;
    oe = sd_oe_n;
    @(posedge clk); #2;
  endtask
  task automatic reg_wr(input logic [7:0] i, input logic [7:0] v);
    wr(ADDR_PORT, i);
    wr(WDATA_PORT, v);
  endtask
  task automatic reg_rd(input logic [7:0] i, output logic [7:0] v,
                        output logic oe);
    wr(ADDR_PORT, i);
    rd(rd_port, v, oe);
  endtask
  task automatic send_key(input logic vend);
    for (int i = 0; i < 32; i++) begin
      wr(ADDR_PORT, vend ? KEY_VEND[i*8 +: 8] : KEY_PNP[i*8 +: 8]);
    end
  endtask
endmodule // pnp_host
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench of the plug and play configuration block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pnp_pkg::*;
  logic        clk, rst_n, rstdrv, iow, ior, oe_n, ee_v, mcu_we;
  logic        auto_wr, pull, wake, jml;
  logic [11:0] sa;
  logic [7:0]  sd_in, sd_out, irq_lines, ee_d, mcu_d, auto_cfg, v;
  logic [71:0] sid;
  logic [15:0] io_base;
  logic [3:0]  irq_sel;
  logic        e;
  int          fails, checks_done, wake_cnt, wr_cnt;
  pnp_cfg_top u_pnp_cfg_top (.CLK(clk), .RST_N(rst_n), .RSTDRV(rstdrv),
    .SA(sa), .IOW(iow), .IOR(ior), .SD_IN(sd_in), .SD_OUT(sd_out),
    .SD_OE_N(oe_n), .IRQ_LINES(irq_lines), .SERIAL_ID(sid),
    .EE_CFG_VALID(ee_v), .EE_CFG_DATA(ee_d), .MCU_CFG_WE(mcu_we),
    .MCU_CFG_DATA(mcu_d), .AUTO_CFG(auto_cfg), .AUTO_CFG_WR(auto_wr),
    .IO_BASE(io_base), .IRQ_SEL(irq_sel), .IRQ_PULL_LOW(pull),
    .MCU_WAKE(wake), .VENDOR_JUMPERLESS_MODE(jml));
  pnp_host u_pnp_host (.clk(clk), .sa(sa), .iow(iow), .ior(ior),
    .sd_in(sd_in), .sd_out(sd_out), .sd_oe_n(oe_n));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (!rst_n) begin
      wake_cnt <= 0;
      wr_cnt <= 0;
    end else begin
      wake_cnt <= wake_cnt + int'(wake);
      wr_cnt <= wr_cnt + int'(auto_wr);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] got,
                       input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s at %0t got %h exp %h", what, $time, got,
               exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Bounded wait; a mode that never arrives ends the run.
  task automatic wait_mode(input logic m);
    int n;
    n = 0;
    while (jml !== m && n < 8) begin
      cyc(1);
      n++;
    end
    check("mode", 16'(jml), 16'(m));
    if (jml !== m) report_and_stop();
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_power_on;
    check("jml", 16'(jml), 16'h0001);
    check("auto", 16'(auto_cfg), 16'h0004);
    check("base", io_base, 16'h03f8);
    check("irq", 16'(irq_sel), 16'h0004);
    ee_d = 8'h2b;
    ee_v = 1'b1;
    cyc(1);
    ee_v = 1'b0;
    cyc(1);
    check("ee load", 16'(auto_cfg), 16'h002b);
    check("ee base", io_base, 16'h03e8);
    check("ee irq", 16'(irq_sel), 16'h000b);
    u_pnp_host.rd(12'h003, v, e);
    check("locked", 16'(e), 16'h0001);
    $display("test power_on done");
  endtask
  task automatic t_key;
    for (int i = 0; i < 5; i++) u_pnp_host.wr(ADDR_PORT, KEY_PNP[i*8 +: 8]);
    u_pnp_host.wr(ADDR_PORT, 8'h00);
    for (int i = 5; i < 32; i++) u_pnp_host.wr(ADDR_PORT, KEY_PNP[i*8 +: 8]);
    check("partial", 16'(jml), 16'h0001);
    u_pnp_host.send_key(1'b0);
    wait_mode(1'b0);
    $display("test key done");
  endtask
  task automatic t_isolate;
    u_pnp_host.reg_wr(IDX_WAKE, 8'h00);
    u_pnp_host.reg_wr(IDX_SET_RD, 8'h80);
    u_pnp_host.rd_port = 12'h203;
    u_pnp_host.reg_rd(IDX_IO_HI, v, e);
    check("no csn", 16'(e), 16'h0001);
    u_pnp_host.wr(ADDR_PORT, IDX_ISO);
    // At 50 ns a clock, 20000 cycles give the 1 ms settling delay.
    cyc(20000);
    for (int b = 0; b < 72; b++) begin
      u_pnp_host.rd(12'h203, v, e);
      check("oe 1st", 16'(e), 16'(!sid[b]));
      if (sid[b]) check("1st", 16'(v), 16'h0055);
      u_pnp_host.rd(12'h203, v, e);
      check("oe 2nd", 16'(e), 16'(!sid[b]));
      if (sid[b]) check("2nd", 16'(v), 16'h00aa);
    end
    u_pnp_host.reg_wr(IDX_CSN, 8'h01);
    u_pnp_host.reg_rd(IDX_IRQ_TYPE, v, e);
    check("cfg", {7'h00, e, v}, 16'h0002);
    $display("test isolate done");
  endtask
  task automatic t_regs;
    int c0;
    u_pnp_host.reg_wr(IDX_IO_HI, 8'h02);
    u_pnp_host.reg_wr(IDX_IO_LO, 8'he8);
    check("base", io_base, 16'h02e8);
    u_pnp_host.reg_rd(IDX_IO_LO, v, e);
    check("lo rd", 16'(v), 16'h00e8);
    u_pnp_host.reg_wr(IDX_IRQ_LVL, 8'h05);
    check("irq", 16'(irq_sel), 16'h0005);
    u_pnp_host.reg_wr(IDX_IRQ_TYPE, 8'hff);
    u_pnp_host.reg_rd(IDX_IRQ_TYPE, v, e);
    check("type ro", 16'(v), 16'h0002);
    c0 = wr_cnt;
    u_pnp_host.reg_wr(IDX_AUTO, 8'h17);
    cyc(3);
    check("save", 16'(wr_cnt - c0), 16'h0001);
    u_pnp_host.reg_rd(IDX_AUTO, v, e);
    check("auto rd", 16'(v), 16'h0017);
    mcu_d = 8'h21;
    mcu_we = 1'b1;
    cyc(1);
    mcu_we = 1'b0;
    cyc(1);
    check("mcu", 16'(auto_cfg), 16'h0021);
    u_pnp_host.reg_rd(8'h40, v, e);
    check("unmapped", 16'(v), 16'h0000);
    $display("test regs done");
  endtask
  task automatic t_sense_wake;
    int c0;
    irq_lines = 8'h96;
    u_pnp_host.reg_wr(IDX_SENSE_EN, 8'h03);
    check("pull", 16'(pull), 16'h0001);
    irq_lines = 8'h00;
    u_pnp_host.reg_rd(IDX_SENSE, v, e);
    check("latched", 16'(v), 16'h0096);
    c0 = wake_cnt;
    u_pnp_host.reg_wr(IDX_MCU_WAKE, 8'h01);
    cyc(3);
    check("wake", 16'(wake_cnt - c0), 16'h0001);
    $display("test sense_wake done");
  endtask
  task automatic t_lose;
    u_pnp_host.reg_wr(IDX_CFG_CTL, 8'h06);
    u_pnp_host.send_key(1'b1);
    wait_mode(1'b1);
    u_pnp_host.reg_wr(IDX_WAKE, 8'h00);
    u_pnp_host.reg_wr(IDX_SET_RD, 8'h80);
    u_pnp_host.wr(ADDR_PORT, IDX_ISO);
    // The rival drives junk above bit 1, which must be ignored.
    u_pnp_host.other_en = 1'b1;
    u_pnp_host.other_val = 8'hfd;
    u_pnp_host.rd(12'h203, v, e);
    u_pnp_host.other_val = 8'h02;
    u_pnp_host.rd(12'h203, v, e);
    u_pnp_host.other_en = 1'b0;
    for (int b = 1; b < 4; b++) begin
      u_pnp_host.rd(12'h203, v, e);
      check("lost", 16'(e), 16'h0001);
      u_pnp_host.rd(12'h203, v, e);
    end
    $display("test lose done");
  endtask
  task automatic t_host_reset;
    rstdrv = 1'b1;
    cyc(1);
    rstdrv = 1'b0;
    cyc(3);
    check("base", io_base, 16'h03e8);
    check("irq", 16'(irq_sel), 16'h0001);
    $display("test host_reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    rstdrv = 1'b0;
    ee_v = 1'b0;
    ee_d = 8'h00;
    mcu_we = 1'b0;
    mcu_d = 8'h00;
    irq_lines = 8'h00;
    sid = 72'ha5_8765_4321_1234_56a8;
    fails = 0;
    checks_done = 0;
    cyc(16);
    rst_n = 1'b1;
    cyc(1);
    t_power_on();
    t_key();
    t_isolate();
    t_regs();
    t_sense_wake();
    t_lose();
    t_host_reset();
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
